/* File: rtl/fbc_pkg.sv */
/*
  Constants of the flash command controller: register map, op codes,
  flash command words and bus cycle timing.
  Assumes a 250 MHz clock and a 16-bit flash with 22 address bits.
*/
package fbc_pkg;
  localparam int CLK_NS = 4;
  localparam int AW = 22;
  localparam int DW = 16;
  // Software register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CTRL_OP_LSB = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_READY = 3;
  localparam int ST_IDN_LSB = 4;
  localparam int ST_BYP_LSB = 8;
  localparam int ST_SEC = 12;
  localparam int ST_ACC = 13;
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // Op codes written to CTRL
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_IDENT = 4'h2;
  localparam logic [3:0] OP_SEC_ENTER = 4'h3;
  localparam logic [3:0] OP_SEC_EXIT = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_BYP_ENTER = 4'h6;
  localparam logic [3:0] OP_BYP_PROG = 4'h7;
  localparam logic [3:0] OP_BYP_EXIT = 4'h8;
  localparam logic [3:0] OP_ACC_ON = 4'h9;
  localparam logic [3:0] OP_ACC_OFF = 4'ha;
  // Flash command words and unlock addresses
  localparam logic [AW-1:0] UNL_A1 = 22'h000555;
  localparam logic [AW-1:0] UNL_A2 = 22'h0002aa;
  localparam logic [DW-1:0] UNL_D1 = 16'h00aa;
  localparam logic [DW-1:0] UNL_D2 = 16'h0055;
  localparam logic [DW-1:0] CMD_RESET = 16'h00f0;
  localparam logic [DW-1:0] CMD_IDENT = 16'h0090;
  localparam logic [DW-1:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [DW-1:0] CMD_SEC_EXIT = 16'h0090;
  localparam logic [DW-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DW-1:0] CMD_BYP_ENTER = 16'h0020;
  localparam logic [DW-1:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [DW-1:0] CMD_EXIT2 = 16'h0000;
  localparam int POLL_BIT = 7;
  localparam int ERR_BIT = 5;
  // Bus cycle times in ns and derived cycle counts (rounded up)
  localparam int T_AS_NS = 4;
  localparam int T_WP_NS = 35;
  localparam int T_DH_NS = 8;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 70;
  localparam int SYNC_CYC = 2;
  localparam logic [4:0] AS_CYC = 5'((T_AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WP_CYC = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] DH_CYC = 5'((T_DH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] WPH_CYC = 5'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] ACC_CYC = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
endpackage

/* File: rtl/fbc_cycle.sv */
/*
  One asynchronous flash bus cycle, write or read, timed by counters.
  Assumes the caller waits for done before the next start.
*/
`timescale 1ns/1ps
`default_nettype none
module fbc_cycle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_read,
  input wire logic [fbc_pkg::AW-1:0] addr,
  input wire logic [fbc_pkg::DW-1:0] wdata,
  output logic done_q,
  output logic [fbc_pkg::DW-1:0] rdata_q,
  output logic [fbc_pkg::AW-1:0] fl_addr_q,
  output logic [fbc_pkg::DW-1:0] fl_dq_out_q,
  output logic fl_dq_oe_q,
  input wire logic [fbc_pkg::DW-1:0] fl_dq_in,
  output logic fl_ce_n_q,
  output logic fl_we_n_q,
  output logic fl_oe_n_q
);
  typedef enum logic [2:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD, CY_READ, CY_REC} fbc_cy_t;
  fbc_cy_t cy_q;
  logic [4:0] cnt_q;
  logic [fbc_pkg::DW-1:0] dq_s1_q, dq_s2_q;
  logic last;
  assign last = (cnt_q == 5'h01);

  // Data inputs pass two flops before use
  always_ff @(posedge clk)
  begin
    dq_s1_q <= fl_dq_in;
    dq_s2_q <= dq_s1_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cy_q <= CY_IDLE;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
      rdata_q <= '0;
      fl_addr_q <= '0;
      fl_dq_out_q <= '0;
      fl_dq_oe_q <= 1'b0;
      fl_ce_n_q <= 1'b1;
      fl_we_n_q <= 1'b1;
      fl_oe_n_q <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      cnt_q <= cnt_q - 5'h01;
      unique case (cy_q)
        CY_IDLE:
        begin
          cnt_q <= 5'h00;
          if (start)
          begin
            fl_addr_q <= addr;
            fl_ce_n_q <= 1'b0;
            fl_oe_n_q <= !is_read;
            fl_dq_out_q <= wdata;
            fl_dq_oe_q <= !is_read;
            cnt_q <= is_read ? fbc_pkg::ACC_CYC : fbc_pkg::AS_CYC;
            cy_q <= is_read ? CY_READ : CY_SETUP;
          end
        end
        CY_SETUP:
          if (last)
          begin
            // Address stable before write strobe falls, data through its rise
            fl_we_n_q <= 1'b0; // R24
            cnt_q <= fbc_pkg::WP_CYC;
            cy_q <= CY_PULSE;
          end
        CY_PULSE:
          if (last)
          begin
            fl_we_n_q <= 1'b1; // R24
            cnt_q <= fbc_pkg::DH_CYC;
            cy_q <= CY_HOLD;
          end
        CY_HOLD:
          if (last)
          begin
            fl_ce_n_q <= 1'b1;
            fl_dq_oe_q <= 1'b0;
            cnt_q <= fbc_pkg::WPH_CYC;
            cy_q <= CY_REC;
          end
        CY_READ:
          if (last)
          begin
            rdata_q <= dq_s2_q;
            fl_ce_n_q <= 1'b1;
            fl_oe_n_q <= 1'b1;
            cnt_q <= fbc_pkg::WPH_CYC;
            cy_q <= CY_REC;
          end
        CY_REC:
          if (last)
          begin
            done_q <= 1'b1;
            cy_q <= CY_IDLE;
          end
      endcase
    end
  end

  we_data_a: assert property (@(posedge clk) disable iff (!rst_n) // R24
    $rose(fl_we_n_q) |-> fl_dq_oe_q && !fl_ce_n_q && $stable(fl_dq_out_q))
    else $error("write data not held across strobe rise");
  we_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // R24
    $fell(fl_we_n_q) |-> !fl_ce_n_q && $stable(fl_addr_q) && fl_oe_n_q)
    else $error("address not stable at strobe fall");
endmodule
`default_nettype wire

/* File: rtl/fbc_host.sv */
/*
  Host controller for a multi-bank flash: runs command sequences on the
  flash pins on orders written to its registers.
  Assumes a plain register port with read data one cycle after the strobe.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Device starts in array read; controller starts with all banks in read.
// R2: Bank returns to read after program; controller clears busy then.
// R3: Suspended banks show status in suspended sectors; reads just return data.
// R4: On error flag during program, controller writes the reset command.
// R5: Reset command returns banks to read; its address is don't care.
// R6: Reset before erase starts returns bank to read mode.
// R7: Reset between program cycles returns bank to read mode.
// R8: Reset ends identification mode of the banks.
// R9: Identification issued only to a bank in read mode.
// R10: Identification is two unlocks then bank address with identify command.
// R11: Sector protection read uses bank and sector address from ADDR.
// R12: Secure region entered by three writes, left by four writes.
// R13: Secure region holds eight word serial number; unavailable while busy.
// R14: No acceleration or bypass while secure region is enabled; secure entry checks bypass of the addressed bank only.
// R15: Word program is two unlocks, setup, then address and data.
// R16: Program end seen on the polling bit; ready/busy shown in status.
// R17: Controller issues no writes while programming runs.
// R18: Programming only clears bits; mismatch ends in error.
// R19: Bypass entry writes 20h; bypass program is A0h then address/data.
// R20: In bypass only bypass program and bypass exit are issued.
// R21: Bypass exit is bank address with 90h, then 00h.
// R22: High voltage on protect/accelerate pin puts device in bypass.
// R23: Improper sequences are refused so the device never sees them.
// R24: Address latched on strobe fall, data on strobe rise.
// R25: Identification and bypass mode kept per bank.
module fbc_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic [fbc_pkg::AW-1:0] fl_addr,
  output logic [fbc_pkg::DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  input wire logic [fbc_pkg::DW-1:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  input wire logic fl_ready_busy,
  output logic acc_hv_q
);
  typedef enum logic [2:0] {SQ_IDLE, SQ_STEP, SQ_WAIT, SQ_POLL, SQ_PWAIT, SQ_RECOVER, SQ_RWAIT} fbc_sq_t;
  localparam logic [fbc_pkg::AW-1:0] ZERO_A = '0;
  fbc_sq_t sq_q;
  logic [3:0] op_q;
  logic [2:0] step_q;
  logic [fbc_pkg::AW-1:0] addr_q;
  logic [fbc_pkg::DW-1:0] wdata_q, rdata_q;
  logic start_q, st_rd_q, err_seen_q;
  logic [fbc_pkg::AW-1:0] st_addr_q;
  logic [fbc_pkg::DW-1:0] st_data_q;
  logic refused_q, error_q, sec_q;
  logic [3:0] idn_q, byp_q;
  logic rb_s1_q, rb_s2_q;
  logic cy_done;
  logic [fbc_pkg::DW-1:0] cy_rdata;
  logic [1:0] bank;
  logic go, ok, sts_clr, fin;
  logic [fbc_pkg::AW+fbc_pkg::DW:0] step_w;

  assign bank = addr_q[fbc_pkg::AW-1:fbc_pkg::AW-2];

  // Number of bus cycles in each sequence
  function automatic logic [2:0] op_len(input logic [3:0] op);
    unique case (op)
      fbc_pkg::OP_READ, fbc_pkg::OP_RESET: op_len = 3'h1;
      fbc_pkg::OP_IDENT, fbc_pkg::OP_SEC_ENTER, fbc_pkg::OP_BYP_ENTER: op_len = 3'h3;
      fbc_pkg::OP_SEC_EXIT, fbc_pkg::OP_PROGRAM: op_len = 3'h4; // R12 R15
      fbc_pkg::OP_BYP_PROG, fbc_pkg::OP_BYP_EXIT, fbc_pkg::OP_ACC_OFF: op_len = 3'h2;
      default: op_len = 3'h0;
    endcase
  endfunction

  // One bus cycle of a sequence: {read, address, data}
  function automatic logic [fbc_pkg::AW+fbc_pkg::DW:0] op_step(input logic [3:0] op, input logic [2:0] i,
                                                             input logic [fbc_pkg::AW-1:0] a,
                                                             input logic [fbc_pkg::DW-1:0] d);
    logic [fbc_pkg::AW-1:0] ba;
    logic [fbc_pkg::DW-1:0] cmd;
    ba = {a[fbc_pkg::AW-1:fbc_pkg::AW-2], fbc_pkg::UNL_A1[fbc_pkg::AW-3:0]};
    unique case (op)
      fbc_pkg::OP_IDENT: cmd = fbc_pkg::CMD_IDENT;
      fbc_pkg::OP_SEC_ENTER: cmd = fbc_pkg::CMD_SEC_ENTER;
      fbc_pkg::OP_SEC_EXIT: cmd = fbc_pkg::CMD_SEC_EXIT;
      fbc_pkg::OP_BYP_ENTER: cmd = fbc_pkg::CMD_BYP_ENTER; // R19
      default: cmd = fbc_pkg::CMD_PROGRAM;
    endcase
    if (op == fbc_pkg::OP_READ)
      op_step = {1'b1, a, d}; // R3
    else if (op == fbc_pkg::OP_RESET)
      op_step = {1'b0, ZERO_A, fbc_pkg::CMD_RESET}; // R5
    else if (op == fbc_pkg::OP_BYP_PROG)
      op_step = (i == 3'h0) ? {1'b0, ba, fbc_pkg::CMD_PROGRAM} : {1'b0, a, d}; // R19
    else if (op == fbc_pkg::OP_BYP_EXIT || op == fbc_pkg::OP_ACC_OFF)
      op_step = (i == 3'h0) ? {1'b0, ba, fbc_pkg::CMD_BYP_EXIT1} : {1'b0, ZERO_A, fbc_pkg::CMD_EXIT2}; // R21
    else if (i == 3'h0)
      op_step = {1'b0, fbc_pkg::UNL_A1, fbc_pkg::UNL_D1}; // R10 R15
    else if (i == 3'h1)
      op_step = {1'b0, fbc_pkg::UNL_A2, fbc_pkg::UNL_D2};
    else if (i == 3'h2)
      op_step = {1'b0, (op == fbc_pkg::OP_IDENT || op == fbc_pkg::OP_BYP_ENTER) ? ba : fbc_pkg::UNL_A1,
                 cmd}; // R10 R19 R25
    else if (op == fbc_pkg::OP_SEC_EXIT)
      op_step = {1'b0, ZERO_A, fbc_pkg::CMD_EXIT2}; // R12
    else
      op_step = {1'b0, a, d}; // R15
  endfunction

  // Which orders the device can take in the present mode
  function automatic logic op_ok(input logic [3:0] op, input logic byp, input logic idn,
                                 input logic sec, input logic acc);
    unique case (op)
      fbc_pkg::OP_READ: op_ok = 1'b1;
      fbc_pkg::OP_RESET: op_ok = !byp; // R6 R7 R20
      fbc_pkg::OP_IDENT, fbc_pkg::OP_PROGRAM: op_ok = !byp && !idn; // R9 R20
      fbc_pkg::OP_SEC_ENTER: op_ok = !byp && !idn && !sec;
      fbc_pkg::OP_SEC_EXIT: op_ok = sec && !byp && !idn;
      fbc_pkg::OP_BYP_ENTER, fbc_pkg::OP_ACC_ON: op_ok = !byp && !idn && !sec; // R14
      fbc_pkg::OP_BYP_PROG: op_ok = byp; // R20
      fbc_pkg::OP_BYP_EXIT: op_ok = byp && !acc;
      fbc_pkg::OP_ACC_OFF: op_ok = acc;
      default: op_ok = 1'b0; // R23
    endcase
  endfunction

  assign go = reg_wr && reg_addr == fbc_pkg::REG_CTRL && sq_q == SQ_IDLE; // R13 R17
  assign ok = op_ok(reg_wdata[fbc_pkg::CTRL_OP_LSB +: 4], byp_q[bank], idn_q[bank], sec_q, acc_hv_q);
  assign sts_clr = reg_wr && reg_addr == fbc_pkg::REG_STATUS;
  assign step_w = op_step(op_q, step_q, addr_q, wdata_q);
  assign fin = (sq_q == SQ_WAIT && cy_done && step_q + 3'h1 == op_len(op_q)
                && op_q != fbc_pkg::OP_PROGRAM && op_q != fbc_pkg::OP_BYP_PROG)
               || (sq_q == SQ_IDLE && go && ok && op_len(reg_wdata[3:0]) == 3'h0);

  // Ready/busy pin passes two flops
  always_ff @(posedge clk)
  begin
    rb_s1_q <= fl_ready_busy;
    rb_s2_q <= rb_s1_q;
  end

  // Software registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      wdata_q <= '0;
      reg_rdata_q <= fbc_pkg::RESET_VAL;
    end
    else
    begin
      if (reg_wr && reg_addr == fbc_pkg::REG_ADDR && sq_q == SQ_IDLE)
        addr_q <= reg_wdata[fbc_pkg::AW-1:0]; // R11
      if (reg_wr && reg_addr == fbc_pkg::REG_WDATA && sq_q == SQ_IDLE)
        wdata_q <= reg_wdata[fbc_pkg::DW-1:0];
      reg_rdata_q <= '0;
      if (reg_rd)
        unique case (reg_addr)
          fbc_pkg::REG_ADDR: reg_rdata_q <= {10'h000, addr_q};
          fbc_pkg::REG_WDATA: reg_rdata_q <= {16'h0000, wdata_q};
          fbc_pkg::REG_RDATA: reg_rdata_q <= {16'h0000, rdata_q};
          fbc_pkg::REG_STATUS: reg_rdata_q <= {18'h00000, acc_hv_q, sec_q, byp_q, idn_q,
                                               rb_s2_q, error_q, refused_q, sq_q != SQ_IDLE}; // R16
          default: reg_rdata_q <= '0;
        endcase
    end
  end

  // Sticky flags: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      refused_q <= 1'b0;
      error_q <= 1'b0;
    end
    else
    begin
      refused_q <= (go && !ok) || (refused_q && !sts_clr); // R23
      error_q <= (sq_q == SQ_RECOVER) || (error_q && !sts_clr); // R18
    end
  end

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sq_q <= SQ_IDLE;
      op_q <= fbc_pkg::OP_READ;
      step_q <= 3'h0;
      start_q <= 1'b0;
      st_rd_q <= 1'b0;
      st_addr_q <= '0;
      st_data_q <= '0;
      err_seen_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      start_q <= 1'b0;
      unique case (sq_q)
        SQ_IDLE:
          if (go && ok && op_len(reg_wdata[3:0]) != 3'h0)
          begin
            op_q <= reg_wdata[fbc_pkg::CTRL_OP_LSB +: 4];
            step_q <= 3'h0;
            err_seen_q <= 1'b0;
            sq_q <= SQ_STEP;
          end
        SQ_STEP:
        begin
          {st_rd_q, st_addr_q, st_data_q} <= step_w;
          start_q <= 1'b1;
          sq_q <= SQ_WAIT;
        end
        SQ_WAIT:
          if (cy_done)
          begin
            if (st_rd_q)
              rdata_q <= cy_rdata;
            step_q <= step_q + 3'h1;
            if (step_q + 3'h1 != op_len(op_q))
              sq_q <= SQ_STEP;
            else if (op_q == fbc_pkg::OP_PROGRAM || op_q == fbc_pkg::OP_BYP_PROG)
              sq_q <= SQ_POLL; // R15 R17
            else
              sq_q <= SQ_IDLE;
          end
        SQ_POLL:
        begin
          {st_rd_q, st_addr_q, st_data_q} <= {1'b1, addr_q, wdata_q};
          start_q <= 1'b1;
          sq_q <= SQ_PWAIT;
        end
        SQ_PWAIT:
          if (cy_done)
          begin
            rdata_q <= cy_rdata;
            if (cy_rdata[fbc_pkg::POLL_BIT] == wdata_q[fbc_pkg::POLL_BIT])
              sq_q <= SQ_IDLE; // R2 R16
            else if (err_seen_q)
              sq_q <= SQ_RECOVER; // R4
            else
            begin
              err_seen_q <= cy_rdata[fbc_pkg::ERR_BIT];
              sq_q <= SQ_POLL;
            end
          end
        SQ_RECOVER:
        begin
          {st_rd_q, st_addr_q, st_data_q} <= {1'b0, ZERO_A, fbc_pkg::CMD_RESET}; // R4 R5
          start_q <= 1'b1;
          sq_q <= SQ_RWAIT;
        end
        SQ_RWAIT:
          if (cy_done)
            sq_q <= SQ_IDLE;
      endcase
    end
  end

  // Host copy of each bank's mode
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      idn_q <= 4'h0; // R1
      byp_q <= 4'h0;
      sec_q <= 1'b0;
      acc_hv_q <= 1'b0;
    end
    else if (fin)
    begin
      unique case (sq_q == SQ_IDLE ? reg_wdata[3:0] : op_q)
        fbc_pkg::OP_RESET: idn_q <= 4'h0; // R5 R8
        fbc_pkg::OP_IDENT: idn_q[bank] <= 1'b1; // R10 R25
        fbc_pkg::OP_SEC_ENTER: sec_q <= 1'b1; // R12
        fbc_pkg::OP_SEC_EXIT: sec_q <= 1'b0; // R12
        fbc_pkg::OP_BYP_ENTER: byp_q[bank] <= 1'b1; // R19 R25
        fbc_pkg::OP_BYP_EXIT: byp_q[bank] <= 1'b0; // R21
        fbc_pkg::OP_ACC_ON:
        begin
          acc_hv_q <= 1'b1; // R22
          byp_q <= 4'hf; // R22
        end
        fbc_pkg::OP_ACC_OFF:
        begin
          acc_hv_q <= 1'b0;
          byp_q <= 4'h0;
        end
        default: idn_q <= idn_q;
      endcase
    end
  end

  fbc_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_q),
    .is_read(st_rd_q),
    .addr(st_addr_q),
    .wdata(st_data_q),
    .done_q(cy_done),
    .rdata_q(cy_rdata),
    .fl_addr_q(fl_addr),
    .fl_dq_out_q(fl_dq_out),
    .fl_dq_oe_q(fl_dq_oe),
    .fl_dq_in(fl_dq_in),
    .fl_ce_n_q(fl_ce_n),
    .fl_we_n_q(fl_we_n),
    .fl_oe_n_q(fl_oe_n)
  );

  unlock_first_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    start_q && step_q == 3'h0 && (op_q == fbc_pkg::OP_IDENT || op_q == fbc_pkg::OP_PROGRAM)
    |-> st_addr_q == fbc_pkg::UNL_A1 && st_data_q == fbc_pkg::UNL_D1 && !st_rd_q)
    else $error("sequence does not open with unlock");
  ident_cmd_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    start_q && op_q == fbc_pkg::OP_IDENT && step_q == 3'h2
    |-> st_data_q == fbc_pkg::CMD_IDENT && st_addr_q[21:20] == bank)
    else $error("identify write lacks bank address");
  prog_poll_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    sq_q == SQ_WAIT && cy_done && op_q == fbc_pkg::OP_PROGRAM && step_q == 3'h3
    |=> sq_q == SQ_POLL ##1 start_q && st_rd_q && st_addr_q == addr_q)
    else $error("program not followed by polling");
  byp_prog_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
    start_q && op_q == fbc_pkg::OP_BYP_PROG && step_q == 3'h0 |-> st_data_q == fbc_pkg::CMD_PROGRAM)
    else $error("bypass program setup wrong");
  byp_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
    start_q && op_q == fbc_pkg::OP_BYP_EXIT && step_q == 3'h1 |-> st_data_q == fbc_pkg::CMD_EXIT2)
    else $error("bypass exit second write wrong");
  sec_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    $fell(sec_q) |-> op_q == fbc_pkg::OP_SEC_EXIT && $past(step_q) == 3'h3)
    else $error("secure region left without four writes");
  err_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    sq_q == SQ_RECOVER |=> start_q && !st_rd_q && st_data_q == fbc_pkg::CMD_RESET)
    else $error("no reset after program error");
  sec_noacc_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    sec_q |-> !acc_hv_q && byp_q == 4'h0)
    else $error("bypass or acceleration while secure");
  ident_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    sq_q == SQ_IDLE && go && reg_wdata[3:0] == fbc_pkg::OP_IDENT && byp_q[bank] |=> sq_q == SQ_IDLE)
    else $error("identify issued to bypass bank");
  prog_done_c: cover property (@(posedge clk) disable iff (!rst_n)
    sq_q == SQ_PWAIT && cy_done ##1 sq_q == SQ_IDLE);
  recover_c: cover property (@(posedge clk) disable iff (!rst_n) sq_q == SQ_RECOVER);
  ident_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(idn_q[0]));
endmodule
`default_nettype wire

/* File: test/fbc_flash_model.sv */
/*
  Behavioural flash device: command decoder, word store, status reads.
  Assumes one host drives its pins and keeps we_n pulses inside ce_n low.
*/
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model (
  input wire logic [21:0] a,
  input wire logic [15:0] d,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic acc,
  output logic [15:0] q,
  output logic rdy,
  output var int bad
);
  logic [15:0] mem [int];
  logic [15:0] pd = 16'h0;
  logic [15:0] old;
  logic [3:0] idn = 4'h0;
  logic [3:0] byp = 4'h0;
  logic [1:0] xb = 2'h0;
  logic sec = 1'b0;
  logic pg = 1'b0;
  logic x90 = 1'b0;
  logic err = 1'b0;
  logic tg = 1'b0;
  int st = 0;
  int bz = 0;
  assign rdy = !(bz > 0 || err);
  initial bad = 0;
  initial q = 16'h0;
  always @(posedge acc) byp = 4'hf;
  always @(negedge acc) byp = 4'h0;
  always @(posedge oe_n) q = ~q;
  always @(negedge oe_n)
  begin
    // Let address settle past the strobe edge
    #1;
    if (bz > 0 && !err) bz--;
    tg = ~tg;
    old = mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
    q = (bz > 0 || err) ? {8'h0, ~pd[7], tg, err, 5'h0} : old;
  end
  always @(posedge we_n)
  begin
    if (!ce_n)
    begin
      if (bz > 0 && !err) bad++;
      else if (pg)
      begin
        old = mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
        mem[int'(a)] = old & d;
        err = |(d & ~old);
        pd = d;
        bz = 3;
        pg = 1'b0;
      end
      else if (d == 16'h00f0)
      begin
        idn = 4'h0;
        err = 1'b0;
        bz = 0;
        st = 0;
      end
      else if (x90 && d == 16'h0000)
      begin
        byp[xb] = 1'b0;
        sec = 1'b0;
        x90 = 1'b0;
      end
      else if (byp[a[21:20]] || acc)
      begin
        if (d == 16'h00a0) pg = 1'b1;
        else if (d == 16'h0090) {x90, xb} = {1'b1, a[21:20]};
        else bad++;
      end
      else if (st == 0 && a[10:0] == 11'h555 && d == 16'h00aa) st = 1;
      else if (st == 1 && a[10:0] == 11'h2aa && d == 16'h0055) st = 2;
      else if (st == 2 && a[10:0] == 11'h555)
      begin
        st = 0;
        if (d == 16'h0090 && sec) x90 = 1'b1;
        else if (d == 16'h0090) idn[a[21:20]] = 1'b1;
        else if (d == 16'h0088) sec = 1'b1;
        else if (d == 16'h00a0) pg = 1'b1;
        else if (d == 16'h0020 && !sec) byp[a[21:20]] = 1'b1;
        else bad++;
      end
      else bad++;
    end
  end
endmodule
`default_nettype wire

/* File: test/fbc_host_tb.sv */
/*
  Register-level bench of the flash host controller.
  Assumes the flash model answers on the flash pins.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module fbc_host_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_q;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out;
  logic [15:0] fl_dq_in;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_ready_busy, acc_hv_q;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int bad;
  always #2 clk = ~clk;
  fbc_host DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ready_busy(fl_ready_busy), .acc_hv_q(acc_hv_q));
  fbc_flash_model u_flash (.a(fl_addr), .d(fl_dq_out), .ce_n(fl_ce_n), .we_n(fl_we_n),
    .oe_n(fl_oe_n), .acc(acc_hv_q), .q(fl_dq_in), .rdy(fl_ready_busy), .bad(bad));
  always @(posedge fl_we_n)
    if (rst_n)
      `CHK("dq drive", 1'b1, fl_dq_oe)
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_q;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK($sformatf("reg %h", a), e, v)
  endtask
  task automatic op(input logic [3:0] o);
    logic [31:0] s;
    int n;
    wr(fbc_pkg::REG_CTRL, {28'h0, o});
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000)
    begin
      rd(fbc_pkg::REG_STATUS, s);
      n++;
    end
    `CHK("busy end", 1'b0, s[0])
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    ck(fbc_pkg::REG_STATUS, 32'h8);
    ck(8'h14, 32'h0);
    $display("test reset done");
    wr(fbc_pkg::REG_ADDR, 32'h100);
    wr(fbc_pkg::REG_WDATA, 32'h1234);
    op(fbc_pkg::OP_PROGRAM);
    ck(fbc_pkg::REG_STATUS, 32'h8);
    op(fbc_pkg::OP_READ);
    ck(fbc_pkg::REG_RDATA, 32'h1234);
    wr(fbc_pkg::REG_WDATA, 32'h00ff);
    op(fbc_pkg::OP_PROGRAM);
    ck(fbc_pkg::REG_STATUS, 32'hc);
    op(fbc_pkg::OP_READ);
    ck(fbc_pkg::REG_RDATA, 32'h0034);
    wr(fbc_pkg::REG_STATUS, 32'h0);
    $display("test program done");
    wr(fbc_pkg::REG_ADDR, 32'h200000);
    op(fbc_pkg::OP_IDENT);
    ck(fbc_pkg::REG_STATUS, 32'h48);
    op(fbc_pkg::OP_PROGRAM);
    ck(fbc_pkg::REG_STATUS, 32'h4a);
    op(fbc_pkg::OP_RESET);
    wr(fbc_pkg::REG_STATUS, 32'h0);
    ck(fbc_pkg::REG_STATUS, 32'h8);
    $display("test ident done");
    wr(fbc_pkg::REG_ADDR, 32'h100000);
    op(fbc_pkg::OP_BYP_ENTER);
    ck(fbc_pkg::REG_STATUS, 32'h208);
    wr(fbc_pkg::REG_ADDR, 32'h100010);
    wr(fbc_pkg::REG_WDATA, 32'h5678);
    op(fbc_pkg::OP_BYP_PROG);
    op(fbc_pkg::OP_RESET);
    ck(fbc_pkg::REG_STATUS, 32'h20a);
    wr(fbc_pkg::REG_STATUS, 32'h0);
    op(fbc_pkg::OP_BYP_EXIT);
    ck(fbc_pkg::REG_STATUS, 32'h8);
    op(fbc_pkg::OP_READ);
    ck(fbc_pkg::REG_RDATA, 32'h5678);
    $display("test bypass done");
    op(fbc_pkg::OP_SEC_ENTER);
    ck(fbc_pkg::REG_STATUS, 32'h1008);
    op(fbc_pkg::OP_ACC_ON);
    op(fbc_pkg::OP_BYP_ENTER);
    ck(fbc_pkg::REG_STATUS, 32'h100a);
    wr(fbc_pkg::REG_STATUS, 32'h0);
    op(fbc_pkg::OP_SEC_EXIT);
    ck(fbc_pkg::REG_STATUS, 32'h8);
    $display("test secure done");
    op(fbc_pkg::OP_ACC_ON);
    ck(fbc_pkg::REG_STATUS, 32'h2f08);
    `CHK("acc pin", 1'b1, acc_hv_q)
    op(fbc_pkg::OP_ACC_OFF);
    ck(fbc_pkg::REG_STATUS, 32'h8);
    `CHK("acc pin", 1'b0, acc_hv_q)
    `CHK("bad writes", 0, bad)
    $display("test acc done");
    conclude();
  end
endmodule
`default_nettype wire
